// File: design/sps_pkg.sv
// constants, carriers and states shared by the separate-port burst sram
// assumes nothing beyond a standard systemverilog compiler
`default_nettype none
package sps_pkg;
  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int WORD_W = 36;
  localparam int ADDR_W = 20;
  localparam int BURST  = 2;
  localparam int PTR_W  = 2;

  // ------------------------------------------------------------
  // address slots and buffer levels
  // ------------------------------------------------------------
  localparam logic             SLOT_READ  = 1'b0;
  localparam logic             SLOT_WRITE = 1'b1;
  localparam logic [PTR_W-1:0] PTR_ONE    = 2'h1;
  localparam logic [PTR_W-1:0] BUF_FULL   = 2'h2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic              echo;
    logic              echo_n;
    logic [WORD_W-1:0] data;
  } sps_beat_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] w0;
    logic [WORD_W-1:0] w1;
  } sps_entry_s;

  localparam sps_beat_s BEAT_IDLE = '0;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_WORD0,
    ENG_WORD1
  } sps_eng_e;
endpackage
`default_nettype wire

// File: design/sps_sram_port.sv
// separate read/write port sram with ddr burst-of-two data
// assumes address, selects and write data are synchronous to the k clocks
//
// Summary of operation
// - read data leaves on its own bus, write data enters on another.
// - one address bus; read and write slots alternate on true clock edges.
// - every address holds two 36-bit words moved as one burst.
// - each port moves a beat on every true and complementary rising edge.
// - only rising edges of both input clocks are used.
// - bypass pin high: first read beat 2.5 cycles after address capture.
// - bypass pin low: first read beat 1 cycle after address capture.
// - reads and writes run independently and never stall each other.
// - each port has its own active-low select from the controller.
// - address, selects and write data land in input registers first.
// - read data, flag and echo clocks leave from output registers.
// - array writes finish on their own behind a buffer, no strobe.
// - read valid flag is high exactly while read beats are driven.
// - a complementary echo clock pair travels with the read beats.
// - reads return the newest data, including writes still in flight.
`timescale 1ns/1ps
`default_nettype none
module sps_sram_port
  import sps_pkg::*;
(
  // core clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // link clocks
  input  wire logic              link_k_clk_in,
  input  wire logic              link_k_n_clk_in,
  // address, selects, mode
  input  wire logic [ADDR_W-1:0] address_in,
  input  wire logic              read_port_select_n_in,
  input  wire logic              write_port_select_n_in,
  input  wire logic              clock_gen_bypass_pin_in,
  // write port
  input  wire logic [WORD_W-1:0] write_data_in,
  // read port
  output logic      [WORD_W-1:0] read_data_out,
  output logic                   read_valid_flag_out,
  output logic                   echo_clock_out,
  output logic                   echo_clock_n_out,
  // buffer status
  output logic                   write_stall_out
);
  // ------------------------------------------------------------
  // storage and state
  // ------------------------------------------------------------
  logic [WORD_W-1:0] mem [2**ADDR_W][BURST];
  sps_entry_s        buf_mem [BURST];

  logic              rst_k_meta;
  logic              rst_k;
  logic              rst_kn_meta;
  logic              rst_kn;
  logic              clock_gen_bypass_pin_meta;
  logic              clock_gen_bypass_pin_sync;

  logic [ADDR_W-1:0] addr_q;
  logic              rsel_n_q;
  logic              wsel_n_q;
  logic              slot_q;
  logic              phase;
  logic [WORD_W-1:0] wbeat0_q;
  logic [WORD_W-1:0] wbeat1_q;

  sps_entry_s        stg;
  logic              stg_arm;
  logic              stg_valid;
  logic [PTR_W-1:0]  wptr;
  logic [PTR_W-1:0]  wptr_g;
  logic [PTR_W-1:0]  rg_meta;
  logic [PTR_W-1:0]  rg_sync;
  logic [PTR_W-1:0]  rptr_k;
  logic [PTR_W-1:0]  fill;
  logic              buf_ready;

  logic [PTR_W-1:0]  rptr;
  logic [PTR_W-1:0]  rptr_g;
  logic [PTR_W-1:0]  wg_meta;
  logic [PTR_W-1:0]  wg_sync;
  logic              buf_valid;
  sps_eng_e          eng;
  sps_eng_e          next_eng;

  logic              rd_now;
  logic              wr_cap;
  logic              wr_take;
  logic [WORD_W-1:0] fwd_w0;
  logic [WORD_W-1:0] fwd_w1;
  logic              s1_valid;
  logic [WORD_W-1:0] s1_w0;
  logic [WORD_W-1:0] s1_w1;
  logic              s2_valid;
  logic [WORD_W-1:0] s2_w1;
  sps_beat_s         k_beat;
  sps_beat_s         kn_next;
  sps_beat_s         kq;
  sps_beat_s         knq;
  sps_beat_s         k_shown;
  sps_beat_s         pins;
  logic              k_live;

  // ------------------------------------------------------------
  // synchronisers into the link domains
  // ------------------------------------------------------------
  always_ff @(posedge link_k_clk_in)
  begin
    rst_k_meta <= reset_in;
    rst_k      <= rst_k_meta;
  end

  always_ff @(posedge link_k_n_clk_in)
  begin
    rst_kn_meta <= reset_in;
    rst_kn      <= rst_kn_meta;
  end

  // the bypass pin is static in use; sampling it costs latency only at a change
  always_ff @(posedge link_k_clk_in)
  begin
    clock_gen_bypass_pin_meta <= clock_gen_bypass_pin_in;
    clock_gen_bypass_pin_sync <= clock_gen_bypass_pin_meta;
  end

  // ------------------------------------------------------------
  // input registers and slot phase
  // ------------------------------------------------------------
  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
    begin
      addr_q   <= '0;
      rsel_n_q <= 1'b1;
      wsel_n_q <= 1'b1;
      slot_q   <= SLOT_READ;
      phase    <= SLOT_READ;
      wbeat1_q <= '0;
    end
    else
    begin
      addr_q   <= address_in;
      rsel_n_q <= read_port_select_n_in;
      wsel_n_q <= write_port_select_n_in;
      wbeat1_q <= write_data_in;
      slot_q   <= phase;
      phase    <= ~phase;
    end
  end

  always_ff @(posedge link_k_n_clk_in)
  begin
    if (rst_kn)
      wbeat0_q <= '0;
    else
      wbeat0_q <= write_data_in;
  end

  // separate selects gate each slot on its own
  assign rd_now  = (slot_q == SLOT_READ) && !rsel_n_q;
  assign wr_cap  = (slot_q == SLOT_WRITE) && !wsel_n_q;
  // a held staging word refuses a new write rather than overwriting it
  assign wr_take = wr_cap && !(stg_valid && !buf_ready);

  // ------------------------------------------------------------
  // write staging and buffer fill side
  // ------------------------------------------------------------
  assign rptr_k    = {rg_sync[1], rg_sync[1] ^ rg_sync[0]};
  assign fill      = PTR_W'(wptr - rptr_k);
  assign buf_ready = (fill != BUF_FULL);

  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
    begin
      stg       <= '0;
      stg_arm   <= 1'b0;
      stg_valid <= 1'b0;
    end
    else
    begin
      stg_arm <= wr_take;
      if (wr_take)
      begin
        stg.addr <= addr_q;
        stg.w0   <= wbeat0_q;
      end
      if (stg_arm)
        stg.w1 <= wbeat1_q;
      if (stg_arm)
        stg_valid <= 1'b1;
      else if (buf_ready)
        stg_valid <= 1'b0;
    end
  end

  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
    begin
      wptr   <= '0;
      wptr_g <= '0;
    end
    else if (stg_valid && buf_ready)
    begin
      wptr   <= PTR_W'(wptr + PTR_ONE);
      wptr_g <= PTR_W'(wptr + PTR_ONE) ^ (PTR_W'(wptr + PTR_ONE) >> 1);
    end
  end

  always_ff @(posedge link_k_clk_in)
  begin
    if (stg_valid && buf_ready)
      buf_mem[wptr[0]] <= stg;
  end

  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
    begin
      rg_meta <= '0;
      rg_sync <= '0;
    end
    else
    begin
      rg_meta <= rptr_g;
      rg_sync <= rg_meta;
    end
  end

  assign write_stall_out = stg_valid && !buf_ready;

  // ------------------------------------------------------------
  // self-timed array writer on the core clock
  // ------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      wg_meta <= '0;
      wg_sync <= '0;
    end
    else
    begin
      wg_meta <= wptr_g;
      wg_sync <= wg_meta;
    end
  end

  assign buf_valid = (rptr_g != wg_sync);

  always_comb
  begin
    next_eng = eng;
    unique case (eng)
      ENG_IDLE:  if (buf_valid) next_eng = ENG_WORD0;
      ENG_WORD0: next_eng = ENG_WORD1;
      ENG_WORD1: next_eng = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      eng <= ENG_IDLE;
    else
      eng <= next_eng;
  end

  // the entry stays counted as pending until both words are in the array;
  // popping in the same cycle keeps the pointer round trip under two write slots
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      rptr   <= '0;
      rptr_g <= '0;
    end
    else if (eng == ENG_WORD0)
    begin
      rptr   <= PTR_W'(rptr + PTR_ONE);
      rptr_g <= PTR_W'(rptr + PTR_ONE) ^ (PTR_W'(rptr + PTR_ONE) >> 1);
    end
  end

  always_ff @(posedge clock_in)
  begin
    // both words land together; word1 state is a recovery slot for the pointer
    if (eng == ENG_WORD0)
    begin
      mem[buf_mem[rptr[0]].addr][0] <= buf_mem[rptr[0]].w0;
      mem[buf_mem[rptr[0]].addr][1] <= buf_mem[rptr[0]].w1;
    end
  end

  // ------------------------------------------------------------
  // read lookup with forwarding from writes in flight
  // ------------------------------------------------------------
  always_comb
  begin
    fwd_w0 = mem[addr_q][0];
    fwd_w1 = mem[addr_q][1];
    if ((fill == BUF_FULL) && (buf_mem[wptr[0]].addr == addr_q))
    begin
      fwd_w0 = buf_mem[wptr[0]].w0;
      fwd_w1 = buf_mem[wptr[0]].w1;
    end
    if ((fill != '0) && (buf_mem[~wptr[0]].addr == addr_q))
    begin
      fwd_w0 = buf_mem[~wptr[0]].w0;
      fwd_w1 = buf_mem[~wptr[0]].w1;
    end
    if (stg_valid && (stg.addr == addr_q))
    begin
      fwd_w0 = stg.w0;
      fwd_w1 = stg.w1;
    end
    // newest write: last word is still sitting in the input register
    if (stg_arm && (stg.addr == addr_q))
    begin
      fwd_w0 = stg.w0;
      fwd_w1 = wbeat1_q;
    end
  end

  // ------------------------------------------------------------
  // read latency pipeline
  // ------------------------------------------------------------
  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
    begin
      s1_valid <= 1'b0;
      s1_w0    <= '0;
      s1_w1    <= '0;
      s2_valid <= 1'b0;
      s2_w1    <= '0;
    end
    else
    begin
      s1_valid <= rd_now;
      s1_w0    <= fwd_w0;
      s1_w1    <= fwd_w1;
      s2_valid <= s1_valid;
      s2_w1    <= s1_w1;
    end
  end

  always_comb
  begin
    k_beat        = BEAT_IDLE;
    k_beat.echo   = 1'b1;
    k_beat.echo_n = 1'b0;
    if (clock_gen_bypass_pin_sync)
    begin
      k_beat.valid = s2_valid;
      k_beat.data  = s2_w1;
    end
    else
    begin
      k_beat.valid = rd_now;
      k_beat.data  = fwd_w0;
    end
  end

  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
      kn_next <= BEAT_IDLE;
    else if (clock_gen_bypass_pin_sync)
    begin
      kn_next.valid <= s1_valid;
      kn_next.data  <= s1_w0;
    end
    else
    begin
      kn_next.valid <= rd_now;
      kn_next.data  <= fwd_w1;
    end
  end

  // ------------------------------------------------------------
  // ddr output registers
  // ------------------------------------------------------------
  // each edge stores its beat xor the other register, so the pins follow the
  // latest rising edge of either clock without a clock-driven multiplexer
  always_ff @(posedge link_k_clk_in)
  begin
    if (rst_k)
    begin
      kq      <= BEAT_IDLE;
      k_shown <= BEAT_IDLE;
      k_live  <= 1'b0;
    end
    else
    begin
      kq      <= k_beat ^ knq;
      k_shown <= k_beat;
      k_live  <= 1'b1;
    end
  end

  always_ff @(posedge link_k_n_clk_in)
  begin
    if (rst_kn)
      knq <= BEAT_IDLE;
    else
      knq <= {kn_next.valid, 1'b0, 1'b1, kn_next.data} ^ kq;
  end

  assign pins                = sps_beat_s'(kq ^ knq);
  assign read_data_out       = pins.data;
  assign read_valid_flag_out = pins.valid;
  assign echo_clock_out      = pins.echo;
  assign echo_clock_n_out    = pins.echo_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence seq_bypass_beats;
    kn_next.valid ##1 k_shown.valid;
  endsequence

  sequence seq_drain;
    (eng == ENG_WORD0) ##1 (eng == ENG_WORD1) ##1 (eng == ENG_IDLE);
  endsequence

  AST_BYPASS_LATENCY: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    (clock_gen_bypass_pin_sync && rd_now) ##1 $stable(clock_gen_bypass_pin_sync) |=> seq_bypass_beats)
    else $error("bypass read beats not at 2.5 cycles");
  AST_LEGACY_LATENCY: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    (!clock_gen_bypass_pin_sync && rd_now) |=> k_shown.valid && kn_next.valid && k_shown.data == $past(fwd_w0))
    else $error("legacy read beat not after one cycle");
  AST_DESELECT_IDLE: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    (!clock_gen_bypass_pin_sync && !rd_now) |=> !k_shown.valid && !kn_next.valid)
    else $error("read beat without a selected read slot");
  AST_SLOT_EXCLUSIVE: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    rd_now |-> !wr_cap ##1 !rd_now)
    else $error("read slot not alternating with write slot");
  AST_PUSH_ADVANCES: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    (stg_valid && buf_ready) |=> wptr == PTR_W'($past(wptr) + PTR_ONE))
    else $error("staged write not pushed into buffer");
  AST_STALL_HOLDS: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    (stg_valid && !buf_ready) |=> stg_valid && $stable(stg.addr))
    else $error("stalled write lost");
  AST_FORWARD_STAGED: assert property (@(posedge link_k_clk_in) disable iff (rst_k)
    (rd_now && !clock_gen_bypass_pin_sync && stg_valid && !stg_arm && stg.addr == addr_q) |=> k_shown.data == $past(stg.w0))
    else $error("read missed data still in staging");
  AST_DRAIN_STEPS: assert property (@(posedge clock_in) disable iff (reset_in)
    (eng == ENG_IDLE && buf_valid) |=> seq_drain)
    else $error("array writer sequence broken");
  AST_OUT_MATCH: assert property (@(posedge link_k_n_clk_in) disable iff (rst_kn || !k_live)
    read_valid_flag_out == k_shown.valid && read_data_out == k_shown.data)
    else $error("read pins differ from true-edge beat");
  AST_ECHO_PHASE: assert property (@(posedge link_k_n_clk_in) disable iff (rst_kn || !k_live)
    echo_clock_out && !echo_clock_n_out)
    else $error("echo clocks out of phase with beats");
endmodule // sps_sram_port
`default_nettype wire

// File: bench/sps_ctrl_model.sv
// controller model: makes the k clocks, drives address, selects and write beats
// assumes the bench queues work through push_read and push_write
`timescale 1ns/1ps
`default_nettype none
module sps_ctrl_model
  import sps_pkg::*;
(
  // reset as the controller sees it
  input  wire logic              reset_in,
  // link clocks
  output logic                   k_clk_out,
  output logic                   k_n_clk_out,
  // address, selects, write data
  output logic      [ADDR_W-1:0] address_out,
  output logic                   rd_sel_n_out,
  output logic                   wr_sel_n_out,
  output logic      [WORD_W-1:0] wdata_out
);
  int                slot_cnt;
  int                next_slot;
  logic [ADDR_W-1:0] rd_q[$];
  sps_entry_s        wr_q[$];
  sps_entry_s        wr_cur;
  logic              wr_go;
  logic              beat1_pend;

  task automatic push_read(input logic [ADDR_W-1:0] addr);
    rd_q.push_back(addr);
  endtask

  task automatic push_write(input sps_entry_s e);
    wr_q.push_back(e);
  endtask

  function automatic logic idle();
    return (rd_q.size() == 0) && (wr_q.size() == 0) && !wr_go && !beat1_pend;
  endfunction

  // ------------------------------------------------------------
  // clocks: free running, the device needs them during reset too
  // ------------------------------------------------------------
  initial
  begin
    k_clk_out    = 1'b0;
    k_n_clk_out  = 1'b0;
    address_out  = '0;
    rd_sel_n_out = 1'b1;
    wr_sel_n_out = 1'b1;
    wdata_out    = '0;
    slot_cnt     = 0;
    wr_go        = 1'b0;
    beat1_pend   = 1'b0;
    #7;
    forever
    begin
      k_clk_out = 1'b1;
      #20 k_clk_out = 1'b0;
      #20 k_n_clk_out = 1'b1;
      #20 k_n_clk_out = 1'b0;
      #20;
    end
  end

  // ------------------------------------------------------------
  // slot driver: odd slots read, even slots write
  // ------------------------------------------------------------
  always @(posedge k_clk_out)
  begin
    slot_cnt = reset_in ? 0 : slot_cnt + 1;
    #1;
    next_slot  = slot_cnt + 1;
    wdata_out  = wr_go ? wr_cur.w0 : ~wdata_out;
    beat1_pend = wr_go;
    wr_go      = 1'b0;
    if (next_slot >= 3 && next_slot % 2 == 1 && rd_q.size() > 0)
    begin
      address_out  = rd_q.pop_front();
      rd_sel_n_out = 1'b0;
      wr_sel_n_out = 1'b1;
    end
    else if (next_slot >= 4 && next_slot % 2 == 0 && wr_q.size() > 0)
    begin
      wr_cur       = wr_q.pop_front();
      address_out  = wr_cur.addr;
      rd_sel_n_out = 1'b1;
      wr_sel_n_out = 1'b0;
      wr_go        = 1'b1;
    end
    else
    begin
      // an unused slot shows a changing address so stale values never match
      address_out  = ~address_out;
      rd_sel_n_out = 1'b1;
      wr_sel_n_out = 1'b1;
    end
  end

  always @(posedge k_n_clk_out)
  begin
    #1;
    wdata_out  = beat1_pend ? wr_cur.w1 : ~wdata_out;
    beat1_pend = 1'b0;
  end
endmodule  // sps_ctrl_model
`default_nettype wire

// File: bench/sps_sram_port_tb.sv
// self-checking bench for the separate-port burst sram
// assumes sps_ctrl_model plays the controller; reference memory lives here
`timescale 1ns/1ps
`default_nettype none
module sps_sram_port_tb
  import sps_pkg::*;
;
  logic              clock_in;
  logic              reset_in;
  logic              core_hold;
  logic              k_clk;
  logic              k_n_clk;
  logic [ADDR_W-1:0] address;
  logic              rd_sel_n;
  logic              wr_sel_n;
  logic              bypass;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] read_data;
  logic              read_valid;
  logic              echo;
  logic              echo_n;
  logic              stall;
  int                mismatches;
  int                tests_run;
  int                seed;
  int                lat;
  int                kc;
  int                nc;
  logic [WORD_W-1:0] mem0 [logic [ADDR_W-1:0]];
  logic [WORD_W-1:0] mem1 [logic [ADDR_W-1:0]];
  int                exp_h[$];
  logic [WORD_W-1:0] exp_d[$];
  logic [ADDR_W-1:0] addr_set [8];
  logic [ADDR_W-1:0] ka;
  logic [ADDR_W-1:0] wa;
  logic              krs;
  logic              kws;
  logic [WORD_W-1:0] kd;
  logic [WORD_W-1:0] nd;
  logic [WORD_W-1:0] wb0;
  logic              w_got;
  logic              w_arm;

  initial clock_in = 1'b0;
  // holding the core clock freezes the array writer so the buffer fills
  always #20 clock_in = core_hold ? 1'b0 : ~clock_in;

  sps_ctrl_model ctrl (
    .reset_in     (reset_in),
    .k_clk_out    (k_clk),
    .k_n_clk_out  (k_n_clk),
    .address_out  (address),
    .rd_sel_n_out (rd_sel_n),
    .wr_sel_n_out (wr_sel_n),
    .wdata_out    (wdata)
  );

  sps_sram_port uut (
    .clock_in                (clock_in),
    .reset_in                (reset_in),
    .link_k_clk_in           (k_clk),
    .link_k_n_clk_in         (k_n_clk),
    .address_in              (address),
    .read_port_select_n_in   (rd_sel_n),
    .write_port_select_n_in  (wr_sel_n),
    .clock_gen_bypass_pin_in (bypass),
    .write_data_in           (wdata),
    .read_data_out           (read_data),
    .read_valid_flag_out     (read_valid),
    .echo_clock_out          (echo),
    .echo_clock_n_out        (echo_n),
    .write_stall_out         (stall)
  );

  // ------------------------------------------------------------
  // compare and closing tasks
  // ------------------------------------------------------------
  task automatic compare_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t ns: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic compare_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_beat(input int h, input logic is_k);
    compare_bit(echo, is_k, "echo clock");
    compare_bit(echo_n, !is_k, "echo clock n");
    if (exp_h.size() > 0 && exp_h[0] == h)
    begin
      compare_bit(read_valid, 1'b1, "valid flag");
      compare_word(read_data, exp_d[0], "read beat");
      void'(exp_h.pop_front());
      void'(exp_d.pop_front());
    end
    else
      compare_bit(read_valid, 1'b0, "idle flag");
  endtask

  // ------------------------------------------------------------
  // reference model fed from the pins the controller drives
  // ------------------------------------------------------------
  always @(posedge k_clk)
  begin
    ka  = address;
    krs = rd_sel_n;
    kws = wr_sel_n;
    kd  = wdata;
    #2;
    kc = ctrl.slot_cnt;
    if (w_arm)
    begin
      mem0[wa] = wb0;
      mem1[wa] = kd;
      w_arm    = 1'b0;
    end
    if (kc >= 4 && kc % 2 == 0 && kws === 1'b0)
    begin
      wa    = ka;
      w_got = 1'b1;
    end
    if (kc >= 3 && kc % 2 == 1 && krs === 1'b0)
    begin
      exp_h.push_back(2 * kc + lat);
      exp_d.push_back(mem0[ka]);
      exp_h.push_back(2 * kc + lat + 1);
      exp_d.push_back(mem1[ka]);
    end
    if (kc >= 4)
      check_beat(2 * kc, 1'b1);
  end

  always @(posedge k_n_clk)
  begin
    nd = wdata;
    #2;
    nc = ctrl.slot_cnt;
    if (w_got)
    begin
      wb0   = nd;
      w_got = 1'b0;
      w_arm = 1'b1;
    end
    if (nc >= 4)
      check_beat(2 * nc + 1, 1'b0);
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic wait_k(input int n);
    repeat (n) @(posedge k_clk);
    #1;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 400 && !ctrl.idle(); i++)
      wait_k(1);
    compare_bit(ctrl.idle(), 1'b1, "controller drained");
    wait_k(5);
  endtask

  task automatic random_run(input int n);
    int                i;
    logic [WORD_W-1:0] w0;
    logic [WORD_W-1:0] w1;
    for (i = 0; i < n; i++)
    begin
      w0 = WORD_W'({$random(seed), $random(seed)});
      w1 = WORD_W'({$random(seed), $random(seed)});
      if ($random(seed) % 4 != 0)
        ctrl.push_write('{addr_set[{$random(seed)} % 8], w0, w1});
      ctrl.push_read(addr_set[{$random(seed)} % 8]);
      wait_k(2);
    end
    wait_idle();
  endtask

  initial
  begin
    seed       = 93;
    mismatches = 0;
    tests_run  = 0;
    lat        = 2;
    core_hold  = 1'b0;
    bypass     = 1'b0;
    reset_in   = 1'b1;
    w_got      = 1'b0;
    w_arm      = 1'b0;
    for (int i = 0; i < 8; i++)
      addr_set[i] = ADDR_W'($random(seed));
    // longer than five core cycles: the k side needs three edges of its own
    repeat (10) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    wait_k(6);
    for (int i = 0; i < 8; i++)
      ctrl.push_write('{addr_set[i], WORD_W'($random(seed)), WORD_W'(~$random(seed))});
    for (int i = 0; i < 100 && ctrl.wr_q.size() > 0; i++)
    begin
      @(posedge k_clk);
      #2;
    end
    ctrl.push_read(addr_set[7]);
    wait_idle();
    $display("test fill and forward done");
    random_run(30);
    $display("test concurrent short latency done");
    bypass = 1'b1;
    lat    = 5;
    wait_k(4);
    random_run(30);
    $display("test concurrent long latency done");
    // let the buffer empty first, or the freeze would strand an older entry
    wait_k(8);
    core_hold = 1'b1;
    for (int i = 0; i < 3; i++)
      ctrl.push_write('{addr_set[i], WORD_W'($random(seed)), WORD_W'($random(seed))});
    wait_idle();
    compare_bit(stall, 1'b1, "stall with core frozen");
    core_hold = 1'b0;
    wait_k(10);
    compare_bit(stall, 1'b0, "stall after drain");
    for (int i = 0; i < 3; i++)
      ctrl.push_read(addr_set[i]);
    wait_idle();
    compare_bit(exp_h.size() == 0, 1'b1, "all read beats seen");
    $display("test buffer full done");
    print_verdict();
  end

  initial
  begin
    #100000;
    mismatches++;
    $display("ERROR %0t ns: watchdog expired", $time);
    print_verdict();
  end
endmodule  // sps_sram_port_tb
`default_nettype wire
